// ### rtl/fptr_defines.svh
// Constants for the flash protection and training register block.
`ifndef FPTR_DEFINES_SVH
`define FPTR_DEFINES_SVH
`define FPTR_OP_WRITE_ENABLE_CMD 8'h06
`define FPTR_OP_WRDI 8'h04
`define FPTR_OP_VOLATILE_WRITE_ENABLE_CMD 8'h50
`define FPTR_OP_CLSR 8'h30
`define FPTR_OP_DPD 8'hB9
`define FPTR_OP_RES 8'hAB
`define FPTR_OP_PNV 8'h43
`define FPTR_OP_WVOL 8'h4A
`define FPTR_OP_RDPAT 8'h41
`define FPTR_OP_SRD 8'h48
`define FPTR_OP_SPRG 8'h42
`define FPTR_OP_SERA 8'h44
`define FPTR_OP_SETLB 8'h01
`define FPTR_OP_RSTEN 8'h66
`define FPTR_OP_RST 8'h99
`define FPTR_NV_RESET 8'h00
`define FPTR_SEC_BYTES 1024
`define FPTR_REGION_BYTES 256
`define FPTR_PSR_PWDLOCK 2
`define FPTR_PSR_SECRDPW 6
`define FPTR_PR_LOCK 0
`define FPTR_CR1_LB_LO 2
`define FPTR_DUMMY_EDGES 8
`endif

// ### rtl/fptr_pkg.sv
// Types shared by the flash protection and training register block.
package fptr_pkg;
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [7:0] data;
  } fptr_cmd_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } fptr_rsp_t;
  typedef enum logic [3:0] {
    FPTR_IDLE = 4'b0001,
    FPTR_EXEC = 4'b0010,
    FPTR_SLEEP = 4'b0100,
    FPTR_DONE = 4'b1000
  } fptr_state_t;
endpackage

// ### rtl/fptr_core.sv
// Flash training pattern registers, security regions and write-enable handling.
`timescale 1ns/1ns
`default_nettype none
`include "fptr_defines.svh"
module fptr_core (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_link,
  input wire fptr_pkg::fptr_cmd_t cmdIn,
  output fptr_pkg::fptr_rsp_t rspOut,
  input wire logic softReset,
  input wire logic dummyPhase,
  output logic [3:0] ioOut,
  output logic ioOe,
  output logic [7:0] protSetupReg,
  input wire logic [7:0] protSetupIn,
  output logic protLockBit,
  output logic [3:0] regionLockBits,
  output logic writeEnableLatch,
  output logic deepSleep,
  output logic progError,
  output logic eraseError
);
  import fptr_pkg::*;

  typedef struct packed {
    fptr_state_t state;
    fptr_cmd_t cmd;
    logic [7:0] nvPat;
    logic nvDone;
    logic [7:0] volPat;
    logic write_enable_latch;
    logic volWel;
    logic [3:0] lockBits;
    logic rstArmed;
    fptr_rsp_t rsp;
    logic [7:0] psr;
    logic psrLoaded;
    logic secWe;
    logic [9:0] secWa;
    logic [7:0] secWd;
  } fptr_sys_t;

  // Power-up contents: the one-time fields start blank, as a fresh part does.
  // The hardware reset below leaves those fields alone, so they act as non-volatile.
  fptr_sys_t sReg = '0;
  fptr_sys_t sNext;
  // The security space starts out erased.
  logic [7:0] secMem [0:`FPTR_SEC_BYTES-1] = '{default: 8'hFF};
  logic [7:0] secRd;

  // Range check on the security address space.
  function automatic logic inRange(input logic [23:0] a);
    inRange = (a < 24'(`FPTR_SEC_BYTES));
  endfunction

  // Region number of a security address.
  function automatic logic [1:0] regionOf(input logic [23:0] a);
    regionOf = a[9:8];
  endfunction

  wire logic pwdLock = sReg.psr[`FPTR_PSR_PWDLOCK];
  wire logic prLock = sReg.psr[`FPTR_PSR_PWDLOCK] & sReg.psr[0];

  // Protection of a region against program and erase.
  function automatic logic regionBlocked(input logic [1:0] r, input logic [3:0] lb,
                                         input logic pw, input logic pl);
    regionBlocked = lb[r] | ((r[1]) & (~pw | ~pl));
  endfunction

  assign secRd = secMem[sReg.cmd.addr[9:0]];

  // Command decoder and executor; each command takes one cycle in EXEC.
  always_comb
  begin
    sNext = sReg;
    sNext.rsp.valid = 1'b0;
    sNext.secWe = 1'b0;
    // First cycle after a hardware reset: take the protection setup and reload the pattern.
    if (!sReg.psrLoaded)
    begin
      sNext.psr = protSetupIn;
      sNext.psrLoaded = 1'b1;
      sNext.volPat = sReg.nvPat;
    end
    if (softReset)
    begin
      sNext.volPat = sReg.nvPat;
      sNext.write_enable_latch = 1'b0;
      sNext.volWel = 1'b0;
      sNext.state = FPTR_IDLE;
    end
    else
    begin
      case (sReg.state)
        FPTR_IDLE:
        begin
          if (cmdIn.valid)
          begin
            sNext.cmd = cmdIn;
            sNext.state = FPTR_EXEC;
          end
        end
        FPTR_SLEEP:
        begin
          if (cmdIn.valid && cmdIn.opcode == `FPTR_OP_RES)
            sNext.state = FPTR_IDLE;
        end
        FPTR_EXEC:
        begin
          sNext.state = FPTR_IDLE;
          sNext.rstArmed = 1'b0;
          case (sReg.cmd.opcode)
            `FPTR_OP_WRITE_ENABLE_CMD: sNext.write_enable_latch = 1'b1;
            `FPTR_OP_VOLATILE_WRITE_ENABLE_CMD:
            begin
              sNext.volWel = 1'b1;
              sNext.write_enable_latch = 1'b0;
            end
            `FPTR_OP_WRDI, `FPTR_OP_CLSR:
            begin
              sNext.write_enable_latch = 1'b0;
              sNext.volWel = 1'b0;
            end
            `FPTR_OP_DPD: sNext.state = FPTR_SLEEP;
            `FPTR_OP_RSTEN: sNext.rstArmed = 1'b1;
            `FPTR_OP_RST:
            begin
              if (sReg.rstArmed)
              begin
                sNext.volPat = sReg.nvPat;
                sNext.write_enable_latch = 1'b0;
                sNext.volWel = 1'b0;
              end
            end
            `FPTR_OP_PNV:
            begin
              if (sReg.write_enable_latch && !sReg.nvDone)
              begin
                sNext.nvPat = sReg.cmd.data;
                sNext.volPat = sReg.cmd.data;
                sNext.nvDone = 1'b1;
              end
              sNext.write_enable_latch = 1'b0;
            end
            `FPTR_OP_WVOL:
            begin
              if (sReg.write_enable_latch || sReg.volWel)
                sNext.volPat = sReg.cmd.data;
              sNext.write_enable_latch = 1'b0;
              sNext.volWel = 1'b0;
            end
            `FPTR_OP_RDPAT:
            begin
              sNext.rsp.valid = 1'b1;
              sNext.rsp.data = sReg.volPat;
            end
            `FPTR_OP_SETLB:
            begin
              if (sReg.write_enable_latch)
                sNext.lockBits = sReg.lockBits | sReg.cmd.data[`FPTR_CR1_LB_LO+:4];
              sNext.write_enable_latch = 1'b0;
            end
            `FPTR_OP_SRD:
            begin
              sNext.rsp.valid = 1'b1;
              // Region 3 under password reads as all ones.
              if (regionOf(sReg.cmd.addr) == 2'd3 && !pwdLock
                  && !sReg.psr[`FPTR_PSR_SECRDPW] && !prLock)
                sNext.rsp.data = 8'hFF;
              else
                sNext.rsp.data = secRd;
            end
            `FPTR_OP_SPRG, `FPTR_OP_SERA:
            begin
              // Out of range or protected requests are dropped with no error flag.
              if (sReg.write_enable_latch && inRange(sReg.cmd.addr)
                  && !regionBlocked(regionOf(sReg.cmd.addr), sReg.lockBits,
                                    pwdLock, prLock))
              begin
                sNext.secWe = 1'b1;
                sNext.secWa = sReg.cmd.addr[9:0];
                sNext.secWd = (sReg.cmd.opcode == `FPTR_OP_SERA) ? 8'hFF :
                              (secRd & sReg.cmd.data);
              end
              sNext.write_enable_latch = 1'b0;
            end
            default: sNext.rsp.valid = 1'b0;
          endcase
        end
        default: sNext.state = FPTR_IDLE;
      endcase
    end
  end

  // Erase writes a single byte here; whole-region erase is folded to one byte per command.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      // The stored pattern, its programmed flag and the lock bits must survive this
      // reset, so they are not touched here; the volatile copy reloads a cycle later.
      sReg.state <= FPTR_IDLE;
      sReg.cmd <= '0;
      sReg.volPat <= `FPTR_NV_RESET;
      sReg.write_enable_latch <= 1'b0;
      sReg.volWel <= 1'b0;
      sReg.rstArmed <= 1'b0;
      sReg.rsp <= '0;
      sReg.psr <= 8'h00;
      sReg.psrLoaded <= 1'b0;
      sReg.secWe <= 1'b0;
      sReg.secWa <= 10'h000;
      sReg.secWd <= 8'h00;
    end
    else
      sReg <= sNext;
  end

  // Security storage holds no reset; it models non-volatile contents.
  always_ff @(posedge clk_sys)
  begin
    if (sReg.secWe)
      secMem[sReg.secWa] <= sReg.secWd;
  end

  assign rspOut = sReg.rsp;
  assign protSetupReg = sReg.psr;
  assign protLockBit = prLock;
  assign regionLockBits = sReg.lockBits;
  assign writeEnableLatch = sReg.write_enable_latch;
  assign deepSleep = (sReg.state == FPTR_SLEEP);
  assign progError = 1'b0;
  assign eraseError = 1'b0;

  // Link side: the volatile pattern is static between writes, so a synchronised
  // change flag guards the capture; the pattern bus is sampled only once stable.
  typedef struct packed {
    logic [2:0] chg;
    logic [7:0] pat;
    logic [2:0] dph;
    logic [2:0] bitIdx;
    logic [3:0] io;
    logic oe;
    logic sent;
  } fptr_link_t;

  fptr_link_t lReg;
  fptr_link_t lNext;
  logic patToggle;
  logic [7:0] patHold;

  // Toggle on each pattern change, holding the word stable for the link side.
  // Two writes closer than a few link cycles could be caught mid-change; hosts do not do that.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      patToggle <= 1'b0;
      patHold <= 8'h00;
    end
    else if (patHold != sReg.volPat)
    begin
      patHold <= sReg.volPat;
      patToggle <= ~patToggle;
    end
  end

  // Pattern shifter: one bit per rising link clock edge during the dummy phase.
  always_comb
  begin
    lNext = lReg;
    lNext.chg = {lReg.chg[1:0], patToggle};
    lNext.dph = {lReg.dph[1:0], dummyPhase};
    if (lReg.chg[2] != lReg.chg[1])
      lNext.pat = patHold;
    lNext.oe = 1'b0;
    lNext.io = 4'h0;
    // One pattern per dummy phase; a longer phase leaves the lines released after it.
    if (lReg.dph[2] && lReg.dph[1])
    begin
      if (lReg.pat != 8'h00 && !lReg.sent)
      begin
        lNext.oe = 1'b1;
        lNext.io = {4{lReg.pat[3'd7 - lReg.bitIdx]}};
        lNext.bitIdx = 3'(lReg.bitIdx + 3'd1);
        if (lReg.bitIdx == 3'(`FPTR_DUMMY_EDGES - 1))
          lNext.sent = 1'b1;
      end
    end
    else
    begin
      lNext.bitIdx = 3'd0;
      lNext.sent = 1'b0;
    end
  end

  always_ff @(posedge clk_link or posedge rst)
  begin
    if (rst)
      lReg <= '0;
    else
      lReg <= lNext;
  end

  assign ioOut = lReg.io;
  assign ioOe = lReg.oe;

  // Training register cannot change once programmed.
  a_nv_once_only: assert property (@(posedge clk_sys) disable iff (rst)
    $past(sReg.nvDone) |-> $stable(sReg.nvPat))
    else $error("non-volatile pattern changed after programming");

  a_nv_copy_vol: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(sReg.nvDone) |-> sReg.volPat == sReg.nvPat)
    else $error("volatile pattern not copied on program");

  a_wel_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (sReg.state == FPTR_EXEC && sReg.cmd.opcode == `FPTR_OP_SPRG) |=> !sReg.write_enable_latch)
    else $error("latch not cleared after security program");

  a_no_wel_no_write: assert property (@(posedge clk_sys) disable iff (rst)
    (sReg.state == FPTR_EXEC && !sReg.write_enable_latch && !sReg.volWel && !softReset
     && !(sReg.cmd.opcode == `FPTR_OP_RST && sReg.rstArmed)) |=> $stable(sReg.volPat))
    else $error("pattern changed without write enable");

  a_sleep_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (deepSleep && !(cmdIn.valid && cmdIn.opcode == `FPTR_OP_RES) && !softReset)
    |=> deepSleep)
    else $error("left deep sleep without release");

  a_lock_sticky: assert property (@(posedge clk_sys) disable iff (rst)
    (sReg.lockBits & ~sNext.lockBits) == 4'h0)
    else $error("region lock bit cleared");

  a_lock_blocks: assert property (@(posedge clk_sys) disable iff (rst)
    sReg.secWe |-> !sReg.lockBits[sReg.secWa[9:8]])
    else $error("write into locked region");

  a_pw_region: assert property (@(posedge clk_sys) disable iff (rst)
    (sReg.secWe && sReg.secWa[9]) |-> (pwdLock && prLock))
    else $error("write into password region");

  a_zero_no_drive: assert property (@(posedge clk_link) disable iff (rst)
    (lReg.pat == 8'h00) |=> !lReg.oe)
    else $error("preamble driven with zero pattern");

  a_reset_reload: assert property (@(posedge clk_sys) disable iff (rst)
    softReset |=> (sReg.volPat == $past(sReg.nvPat) && !sReg.write_enable_latch))
    else $error("soft reset did not reload pattern");
endmodule
`default_nettype wire

// ### verification/fptr_host_model.sv
// Host-side link model that clocks frames and captures the training bits.
`timescale 1ns/1ns
`default_nettype none
module fptr_host_model (
  output logic clkLink,
  output logic dummyPhase,
  input wire logic [3:0] ioOut,
  input wire logic ioOe
);
  initial
  begin
    clkLink = 1'b0;
    dummyPhase = 1'b0;
  end

  // The link clock stands still between calls, as a real host does.
  task automatic pulses(input int n);
    repeat (n)
    begin
      clkLink = 1'b1;
      #62;
      clkLink = 1'b0;
      #63;
    end
  endtask

  // Lead edges let the pattern cross first; then the dummy cycles run.
  task automatic frame(output logic [7:0] got, output int nOe, output int nBad);
    got = 8'h00;
    nOe = 0;
    nBad = 0;
    pulses(5);
    // Raise the phase in the low half so that it never meets a rising edge in one step.
    clkLink = 1'b1;
    #62;
    clkLink = 1'b0;
    dummyPhase = 1'b1;
    #63;
    repeat (16)
    begin
      pulses(1);
      if (ioOe === 1'b1)
      begin
        got = {got[6:0], ioOut[0]};
        nOe++;
        if (ioOut !== {4{ioOut[0]}})
          nBad++;
      end
    end
    dummyPhase = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### verification/fptr_core_bench.sv
// Self-checking bench for the training pattern and protection core.
`timescale 1ns/1ns
`default_nettype none
module fptr_core_bench;
  import fptr_pkg::*;
  logic clk_sys, rst, softReset, clkLink, dummyPhase, ioOe;
  logic protLockBit, writeEnableLatch, deepSleep, progError, eraseError;
  logic [7:0] protSetupIn, protSetupReg, rd, got;
  logic [3:0] ioOut, regionLockBits;
  fptr_cmd_t cmdIn;
  fptr_rsp_t rspOut;
  int failCount = 0;
  int nCompared = 0;
  int cycles = 0;
  int nOe, nBad;

  fptr_core DUT (.clk_sys(clk_sys), .rst(rst), .clk_link(clkLink), .cmdIn(cmdIn),
    .rspOut(rspOut), .softReset(softReset), .dummyPhase(dummyPhase), .ioOut(ioOut),
    .ioOe(ioOe), .protSetupReg(protSetupReg), .protSetupIn(protSetupIn),
    .protLockBit(protLockBit), .regionLockBits(regionLockBits),
    .writeEnableLatch(writeEnableLatch), .deepSleep(deepSleep),
    .progError(progError), .eraseError(eraseError));

  fptr_host_model host (.clkLink(clkLink), .dummyPhase(dummyPhase), .ioOut(ioOut),
    .ioOe(ioOe));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic finishTest();
    if (failCount == 0 && nCompared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // A hang is cut short well beyond the roughly nine hundred cycles the run needs.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      failCount++;
      finishTest();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      failCount++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle command, then four cycles that catch any read answer.
  task automatic send(input logic [7:0] o, input logic [23:0] a = 24'h0,
    input logic [7:0] d = 8'h00);
    rd = 8'hXX;
    @(negedge clk_sys);
    cmdIn = '{1'b1, o, a, d};
    repeat (4)
    begin
      @(negedge clk_sys);
      cmdIn.valid = 1'b0;
      if (rspOut.valid === 1'b1)
        rd = rspOut.data;
    end
  endtask

  // Hardware reset over at least one edge of each clock, released off the edges.
  task automatic hwReset(input logic [7:0] setup);
    protSetupIn = setup;
    rst = 1'b1;
    host.pulses(1);
    @(negedge clk_sys);
    rst = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask

  task automatic softPulse();
    @(negedge clk_sys);
    softReset = 1'b1;
    @(negedge clk_sys);
    softReset = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask

  initial
  begin
    cmdIn = '0;
    rst = 1'b1;
    softReset = 1'b0;
    protSetupIn = 8'h00;
    fork
      host.pulses(1);
    join_none
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    check(writeEnableLatch, 1'b0);
    send(8'h41);
    check(rd, 8'h00);
    send(8'h4A, 24'h0, 8'hA5);
    send(8'h41);
    check(rd, 8'h00);
    send(8'h06);
    check(writeEnableLatch, 1'b1);
    send(8'h4A, 24'h0, 8'hA5);
    check(writeEnableLatch, 1'b0);
    send(8'h41);
    check(rd, 8'hA5);
    host.frame(got, nOe, nBad);
    check(got, 8'hA5);
    check(nOe, 8);
    check(nBad, 0);
    softPulse();
    send(8'h41);
    check(rd, 8'h00);
    host.frame(got, nOe, nBad);
    check(nOe, 0);
    send(8'h06);
    send(8'h43, 24'h0, 8'h34);
    send(8'h41);
    check(rd, 8'h34);
    send(8'h06);
    send(8'h43, 24'h0, 8'h5A);
    softPulse();
    send(8'h41);
    check(rd, 8'h34);
    // Erase, then program region 0 with the latch set each time.
    send(8'h06);
    send(8'h44);
    send(8'h48);
    check(rd, 8'hFF);
    send(8'h06);
    send(8'h42, 24'h0, 8'h3C);
    send(8'h48);
    check(rd, 8'h3C);
    send(8'h06);
    send(8'h42, 24'h100, 8'h12);
    send(8'h48, 24'h100);
    check(rd, 8'h12);
    send(8'h06);
    send(8'h44, 24'h100);
    send(8'h48, 24'h100);
    check(rd, 8'hFF);
    send(8'h48, 24'h200);
    check(rd, 8'hFF);
    send(8'h06);
    send(8'h42, 24'h200, 8'h00);
    send(8'h48, 24'h200);
    check(rd, 8'hFF);
    send(8'h48, 24'h300);
    check(rd, 8'hFF);
    send(8'h06);
    send(8'h42, 24'h400, 8'h00);
    check(progError, 1'b0);
    check(writeEnableLatch, 1'b0);
    send(8'h06);
    send(8'h44, 24'h400);
    check(eraseError, 1'b0);
    send(8'h06);
    send(8'h01, 24'h0, 8'h04);
    check(regionLockBits, 4'h1);
    send(8'h06);
    send(8'h42, 24'h0, 8'h00);
    send(8'h48);
    check(rd, 8'h3C);
    send(8'h06);
    send(8'hB9);
    check(deepSleep, 1'b1);
    send(8'h04);
    check(writeEnableLatch, 1'b1);
    send(8'hAB);
    check(deepSleep, 1'b0);
    // The volatile write-enable comes first, as the host must do.
    send(8'h50);
    check(writeEnableLatch, 1'b0);
    send(8'h4A, 24'h0, 8'h77);
    send(8'h41);
    check(rd, 8'h77);
    send(8'h66);
    send(8'h99);
    send(8'h41);
    check(rd, 8'h34);
    // Hardware reset with the protection lock released.
    hwReset(8'h05);
    check(protLockBit, 1'b1);
    check(protSetupReg, 8'h05);
    send(8'h41);
    check(rd, 8'h34);
    send(8'h06);
    send(8'h42, 24'h200, 8'h00);
    send(8'h48, 24'h200);
    check(rd, 8'h00);
    send(8'h06);
    send(8'h42, 24'h300, 8'h00);
    // Lock the protection again; region 3 now holds 00h behind the password.
    send(8'h06);
    hwReset(8'h00);
    check(writeEnableLatch, 1'b0);
    check(protLockBit, 1'b0);
    check(protSetupReg, 8'h00);
    send(8'h48, 24'h300);
    check(rd, 8'hFF);
    send(8'h06);
    send(8'h44, 24'h200);
    send(8'h48, 24'h200);
    check(rd, 8'h00);
    finishTest();
  end
endmodule
`default_nettype wire
